// ### frf_defines.svh
// constants for the frame receive filter
`ifndef FRF_DEFINES_SVH
`define FRF_DEFINES_SVH
`define FRF_MIN_OCT 11'd64
`define FRF_MAX_OCT 11'd1518
`define FRF_FCS_OCT 11'd4
`define FRF_DST_OCT 11'd6
`define FRF_SRC_END 11'd12
`define FRF_TYPE_END 11'd14
`define FRF_CRC_POLY 32'h04c11db7
`define FRF_CRC_INIT 32'hffffffff
`define FRF_CRC_RESID 32'hc704dd7b
`define FRF_BCAST 48'hffffffffffff
`define FRF_MCAST_BIT 40
`define FRF_FIFO_DEPTH 4
`define FRF_RING_DEPTH 64
`endif

// ### frf_phy_model.sv
// physical layer receiver model: carrier sense and serial bits
`timescale 1ns/1ps
module frf_phy_model (
   // clock
   input wire logic clk_i,
   // line toward the receiver
   output logic crs_o = 1'b0,
   output logic bit_o,
   output logic vld_o = 1'b0
);
   logic hold_r = 1'b0;
   logic bit_v = 1'b0;
   logic junk_r = 1'b0;
   // data line is stale between strobes, so it keeps moving there
   always @(posedge clk_i) junk_r <= ~junk_r;
   assign bit_o = hold_r ? bit_v : junk_r;
   // one strobe every gap clocks; carrier alone frames the bits
   task automatic send(input byte unsigned f[$], input int xb, input int gap);
      int nb;
      nb = f.size() * 8 + xb;
      @(posedge clk_i);
      #1 crs_o = 1'b1;
      // one quiet edge lets the receiver open the frame before the first strobe
      @(posedge clk_i);
      for (int i = 0; i < nb; i++) begin
         repeat (gap - 1) @(posedge clk_i);
         #1 hold_r = 1'b1;
         bit_v = (i < f.size() * 8) ? f[i / 8][i % 8] : i[0];
         vld_o = 1'b1;
         @(posedge clk_i);
         #1 hold_r = 1'b0;
         vld_o = 1'b0;
      end
      repeat (2) @(posedge clk_i);
      #1 crs_o = 1'b0;
   endtask : send
endmodule : frf_phy_model

// ### frf_pkg.sv
// types shared by the frame receive filter
package frf_pkg;
   typedef enum logic [1:0] {fld_dst, fld_src, fld_type, fld_data} frf_fld_t;
   typedef enum logic [2:0] {st_ok, st_fcs_err, st_align_err, st_too_long, st_overrun} frf_stat_t;
   typedef enum logic [1:0] {s_idle, s_recv, s_flush} frf_state_t;
   typedef struct packed {
      logic [7:0] octet;
      frf_fld_t fld;
      logic last;
      frf_stat_t stat;
   } frf_word_t;
   typedef struct packed {
      logic [47:0] station_addr;
      logic mcast_en;
   } frf_mgmt_t;
endpackage : frf_pkg

// ### frf_rx.sv
// frame receive filter: delimiting, address filter, fcs check, fragment drop, output fifo
`timescale 1ns/1ps
`include "frf_defines.svh"

// Behaviour
// R1: frame start and end come only from carrier sense.
// R2: frames beyond 1518 octets are cut off and flagged too long.
// R3: trailing partial octet of a complete frame is dropped.
// R4: partial octet plus bad check sequence reports alignment error.
// R5: destination equal to station address is accepted.
// R6: management loads the station address, possibly into several controllers.
// R7: broadcast destination is always accepted.
// R8: multicast-group destinations accepted only while multicast is enabled.
// R9: client filters individual multicast groups itself.
// R10: crc over all bits except fcs; mismatch is reported as error.
// R11: destination, source, type and data are delivered to the client.
// R12: frames shorter than 64 octets are discarded as fragments.
// R13: discarded fragments raise no error toward the client.
// R14: crc complements first 32 bits, divides by generator, complements remainder.
// R15: broadcast is the all-ones 48-bit address.
// R16: unmatched destinations are dropped silently without status.
module frf_fifo #(
   parameter int W = 14,
   parameter int D = `FRF_FIFO_DEPTH
) (
   // clock and control
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   logic [W-1:0] mem_r [D];
   logic [W-1:0] mem_nxt [D];
   logic [D-1:0] vld_r;
   logic [D-1:0] vld_nxt;
   logic [D-1:0] sh_vld;
   logic [W-1:0] sh_dat [D];
   logic pop;
   logic push;
   // head sits in entry 0 so the outputs come straight from flops
   assign pop = out_ready_i && vld_r[0];
   assign push = in_valid_i && !vld_r[D-1];
   assign in_ready_o = !vld_r[D-1];
   assign out_valid_o = vld_r[0];
   assign out_data_o = mem_r[0];
   for (genvar i = 0; i < D; i++) begin : g_ent
      logic below;
      if (i == D-1) begin : g_top
         always_comb begin
            sh_vld[i] = pop ? 1'b0 : vld_r[i];
            sh_dat[i] = mem_r[i];
         end
      end else begin : g_mid
         always_comb begin
            sh_vld[i] = pop ? vld_r[i+1] : vld_r[i];
            sh_dat[i] = pop ? mem_r[i+1] : mem_r[i];
         end
      end
      if (i == 0) begin : g_first
         assign below = 1'b1;
      end else begin : g_rest
         assign below = sh_vld[i-1];
      end
      always_comb begin
         vld_nxt[i] = sh_vld[i] || (push && !sh_vld[i] && below);
         mem_nxt[i] = (push && !sh_vld[i] && below) ? in_data_i : sh_dat[i];
      end
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            vld_r[i] <= 1'b0;
            mem_r[i] <= '0;
         end else if (ce_i) begin
            vld_r[i] <= vld_nxt[i];
            mem_r[i] <= mem_nxt[i];
         end
      end
   end
endmodule : frf_fifo
module frf_rx (
   // clock, reset, clock enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // physical layer
   input wire logic crs_i,
   input wire logic rx_bit_i,
   input wire logic rx_bit_vld_i,
   // network management
   input wire frf_pkg::frf_mgmt_t mgmt_i,
   // client layer stream
   output logic out_valid_o,
   output frf_pkg::frf_word_t out_word_o,
   input wire logic out_ready_i
);
   import frf_pkg::*;
   frf_state_t state_r, state_nxt;
   logic crs_q_r;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] bitn_r, bitn_nxt;
   logic [10:0] oct_r, oct_nxt;
   logic [10:0] rd_r, rd_nxt;
   logic [31:0] crc_r, crc_nxt;
   logic [31:0] crc_oct_r, crc_oct_nxt;
   logic [47:0] dst_r, dst_nxt;
   logic accept_r, accept_nxt;
   logic long_r, long_nxt;
   logic ovr_r, ovr_nxt;
   logic [7:0] ring_r [`FRF_RING_DEPTH];
   logic [7:0] ring_nxt [`FRF_RING_DEPTH];
   logic push;
   logic fifo_rdy;
   frf_word_t pword;
   function automatic frf_fld_t fld_of(input logic [10:0] j);
      if (j < `FRF_DST_OCT) return fld_dst;
      else if (j < `FRF_SRC_END) return fld_src;
      else if (j < `FRF_TYPE_END) return fld_type;
      else return fld_data;
   endfunction : fld_of
   function automatic logic addr_match(input logic [47:0] d, input frf_mgmt_t m);
      return (d == m.station_addr) // see R5
         || (d == `FRF_BCAST) // see R7 see R15
         || (m.mcast_en && d[`FRF_MCAST_BIT]); // see R8
   endfunction : addr_match
   always_comb begin
      state_nxt = state_r;
      sh_nxt = sh_r;
      bitn_nxt = bitn_r;
      oct_nxt = oct_r;
      rd_nxt = rd_r;
      crc_nxt = crc_r;
      crc_oct_nxt = crc_oct_r;
      dst_nxt = dst_r;
      accept_nxt = accept_r;
      long_nxt = long_r;
      ovr_nxt = ovr_r;
      ring_nxt = ring_r;
      push = 1'b0;
      pword = '0;
      case (state_r)
         s_idle: begin
            if (crs_i && !crs_q_r) begin // see R1
               state_nxt = s_recv;
               bitn_nxt = 3'd0;
               oct_nxt = 11'd0;
               crc_nxt = `FRF_CRC_INIT; // see R14
               crc_oct_nxt = `FRF_CRC_INIT;
               accept_nxt = 1'b0;
               long_nxt = 1'b0;
               ovr_nxt = 1'b0;
            end
         end
         s_recv: begin
            if (!crs_i) begin // see R1
               // fragments and unmatched frames vanish without a word to the client
               if (oct_r >= `FRF_MIN_OCT && accept_r) begin // see R12 see R13 see R16
                  state_nxt = s_flush;
                  rd_nxt = oct_r - `FRF_MIN_OCT;
               end else begin
                  state_nxt = s_idle;
               end
            end else if (rx_bit_vld_i && !long_r) begin
               if (oct_r == `FRF_MAX_OCT) begin
                  long_nxt = 1'b1; // see R2
               end else begin
                  crc_nxt = {crc_r[30:0], 1'b0} ^ ((crc_r[31] ^ rx_bit_i) ? `FRF_CRC_POLY : 32'h0); // see R10
                  sh_nxt = {rx_bit_i, sh_r[7:1]};
                  bitn_nxt = bitn_r + 3'd1;
                  if (bitn_r == 3'd7) begin
                     // crc kept at octet boundaries so excess bits fall out of the check
                     crc_oct_nxt = crc_nxt; // see R3
                     oct_nxt = oct_r + 11'd1;
                     ring_nxt[oct_r[5:0]] = sh_nxt;
                     if (oct_r < `FRF_DST_OCT) dst_nxt = {dst_r[39:0], sh_nxt};
                     if (oct_r == `FRF_DST_OCT - 11'd1) accept_nxt = addr_match({dst_r[39:0], sh_nxt}, mgmt_i);
                     // ring delays output by 64 octets so fragments never reach the fifo
                     if (oct_r >= `FRF_MIN_OCT && accept_r) begin // see R12
                        // the wire cannot be stalled; a full fifo here loses the octet
                        if (fifo_rdy) begin
                           push = 1'b1;
                           pword.octet = ring_r[oct_r[5:0]];
                           pword.fld = fld_of(oct_r - `FRF_MIN_OCT); // see R11
                        end else begin
                           ovr_nxt = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         s_flush: begin
            if (fifo_rdy) begin
               push = 1'b1;
               pword.octet = ring_r[rd_r[5:0]];
               pword.fld = fld_of(rd_r); // see R11
               pword.last = (rd_r + `FRF_FCS_OCT + 11'd1 == oct_r); // see R3
               if (long_r) pword.stat = st_too_long; // see R2
               else if (ovr_r) pword.stat = st_overrun;
               else if (crc_oct_r != `FRF_CRC_RESID) // see R10
                  pword.stat = (bitn_r != 3'd0) ? st_align_err : st_fcs_err; // see R4
               else pword.stat = st_ok;
               if (!pword.last) pword.stat = st_ok;
               rd_nxt = rd_r + 11'd1;
               if (pword.last) state_nxt = s_idle;
            end
         end
         default: state_nxt = s_idle;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= s_idle;
         crs_q_r <= 1'b1;
         sh_r <= '0;
         bitn_r <= '0;
         oct_r <= '0;
         rd_r <= '0;
         crc_r <= `FRF_CRC_INIT;
         crc_oct_r <= `FRF_CRC_INIT;
         dst_r <= '0;
         accept_r <= 1'b0;
         long_r <= 1'b0;
         ovr_r <= 1'b0;
         for (int i = 0; i < `FRF_RING_DEPTH; i++) ring_r[i] <= '0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         crs_q_r <= crs_i;
         sh_r <= sh_nxt;
         bitn_r <= bitn_nxt;
         oct_r <= oct_nxt;
         rd_r <= rd_nxt;
         crc_r <= crc_nxt;
         crc_oct_r <= crc_oct_nxt;
         dst_r <= dst_nxt;
         accept_r <= accept_nxt;
         long_r <= long_nxt;
         ovr_r <= ovr_nxt;
         ring_r <= ring_nxt;
      end
   end
   frf_fifo #(.W($bits(frf_word_t)), .D(`FRF_FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .in_valid_i(push),
      .in_data_i(pword),
      .in_ready_o(fifo_rdy),
      .out_valid_o(out_valid_o),
      .out_data_o(out_word_o),
      .out_ready_i(out_ready_i)
   );
   // checks
   logic dec_evt;
   logic [47:0] dec_addr;
   assign dec_evt = ce_i && state_r == s_recv && crs_i && rx_bit_vld_i && !long_r && bitn_r == 3'd7
      && oct_r == `FRF_DST_OCT - 11'd1 && oct_r != `FRF_MAX_OCT;
   assign dec_addr = {dst_r[39:0], rx_bit_i, sh_r[7:1]};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence frag_end;
      ce_i && state_r == s_recv && !crs_i && oct_r < `FRF_MIN_OCT;
   endsequence
   sequence frame_last;
      ce_i && push && pword.last;
   endsequence
   a_frame_start: assert property (ce_i && state_r == s_idle && crs_i && !crs_q_r |=> state_r == s_recv) // see R1
      else $error("carrier rise did not start reception");
   a_long_cut: assert property (long_r && state_r == s_recv |-> oct_r == `FRF_MAX_OCT) // see R2
      else $error("long frame not cut at max octets");
   a_last_index: assert property (frame_last |-> rd_r + `FRF_FCS_OCT + 11'd1 == oct_r && pword.fld == fld_data) // see R3
      else $error("last word not at final whole data octet");
   a_align_stat: assert property (frame_last and pword.stat == st_align_err |-> bitn_r != 3'd0) // see R4
      else $error("alignment error without excess bits");
   a_station_take: assert property (dec_evt && dec_addr == mgmt_i.station_addr |=> accept_r) // see R5
      else $error("own address frame rejected");
   a_bcast_take: assert property (dec_evt && dec_addr == `FRF_BCAST |=> accept_r) // see R7
      else $error("broadcast frame rejected");
   a_mcast_gate: assert property (dec_evt && dec_addr[`FRF_MCAST_BIT] && !mgmt_i.mcast_en // see R8
      && dec_addr != `FRF_BCAST && dec_addr != mgmt_i.station_addr |=> !accept_r)
      else $error("multicast accepted while disabled");
   a_crc_ok: assert property (frame_last and pword.stat == st_ok |-> crc_oct_r == `FRF_CRC_RESID) // see R10
      else $error("good status with bad check sequence");
   a_frag_drop: assert property (frag_end |-> !push ##1 state_r == s_idle) // see R12
      else $error("fragment not discarded");
   a_push_accept: assert property (push |-> accept_r) // see R16
      else $error("unmatched frame reached the client");
   a_frame_done: assert property (frame_last |=> state_r == s_idle) // see R11
      else $error("reception not closed after last word");
endmodule : frf_rx

// ### frf_tb.sv
// self-checking bench for the frame receive filter
`timescale 1ns/1ps
module testbench;
   import frf_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic out_ready_i = 1'b0;
   logic crs, rxb, vld, out_valid;
   frf_mgmt_t mgmt_i = '0;
   frf_word_t out_word;
   frf_word_t got[$];
   logic [47:0] sta, mc;
   int miscompares = 0;
   int n_checks = 0;
   int stall = 0;
   int bad, xb;
   frf_rx DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .crs_i(crs), .rx_bit_i(rxb), .rx_bit_vld_i(vld),
      .mgmt_i(mgmt_i), .out_valid_o(out_valid), .out_word_o(out_word), .out_ready_i(out_ready_i));
   frf_phy_model u_phy (.clk_i(clk_i), .crs_o(crs), .bit_o(rxb), .vld_o(vld));
   always #12.5 clk_i = ~clk_i;
   // client takes words at random, and none while stalled so the fifo fills
   always @(posedge clk_i) begin
      #1 out_ready_i = (stall == 0) && ($urandom_range(3) != 0);
   end
   // recorded away from the edge: head and ready are settled, the word leaves at the next edge
   always @(negedge clk_i) begin
      if (out_valid === 1'b1 && out_ready_i === 1'b1) got.push_back(out_word);
   end
   function automatic logic [31:0] fcs_of(input byte unsigned f[$]);
      logic [31:0] c;
      c = 32'hffffffff;
      foreach (f[i])
         for (int k = 0; k < 8; k++)
            c = (c[0] ^ f[i][k]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      return ~c;
   endfunction : fcs_of
   task automatic chk(input string what, input logic [31:0] exp, seen);
      n_checks++;
      if (exp !== seen) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // mode 0 compares every word, 1 only the closing word, 2 as 1 with the client stalled
   task automatic run(input logic [47:0] dst, input int len, xb, bad, acc, input frf_stat_t st, input int mode);
      byte unsigned f[$];
      logic [31:0] c;
      frf_word_t w;
      int n;
      for (int i = 0; i < 6; i++) f.push_back(dst[47 - 8 * i -: 8]);
      while (f.size() < len - 4) f.push_back(8'($urandom));
      c = fcs_of(f) ^ 32'(bad);
      for (int i = 0; i < 4; i++) f.push_back(c[8 * i +: 8]);
      got.delete();
      stall = (mode == 2);
      // the longest frame goes at the fastest bit spacing to keep the run short
      u_phy.send(f, xb, len > 100 ? 1 : $urandom_range(4, 1));
      stall = 0;
      repeat (300) @(posedge clk_i);
      #1 n = acc ? len - 4 : 0;
      if (mode == 0) begin
         chk("word count", 32'(n), 32'(got.size()));
         foreach (got[i]) begin
            w.octet = f[i];
            w.fld = i < 6 ? fld_dst : i < 12 ? fld_src : i < 14 ? fld_type : fld_data;
            w.last = (i == n - 1);
            w.stat = w.last ? st : st_ok;
            chk("word", 32'(w), 32'(got[i]));
         end
      end else begin
         chk("closing status", 32'({1'b1, st}), 32'({got[$].last, got[$].stat}));
      end
   endtask : run
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // at the slowest random spacing the whole run stays near 60k cycles
   initial begin
      repeat (80000) @(posedge clk_i);
      miscompares++;
      conclude();
   end
   initial begin
      void'($urandom(32'h85871359));
      sta = 48'({$urandom, $urandom});
      sta[40] = 1'b0;
      mc = 48'({$urandom, $urandom}) | 48'h010000000000;
      mgmt_i.station_addr = sta;
      repeat (4) @(posedge clk_i);
      #1 srst_i = 1'b0;
      run(sta, 64, 0, 0, 1, st_ok, 0);
      run(48'hffffffffffff, 64, 0, 0, 1, st_ok, 0);
      run(sta ^ 48'h1, 70, 0, 0, 0, st_ok, 0);
      run(mc, 64, 0, 0, 0, st_ok, 0);
      mgmt_i.mcast_en = 1'b1;
      run(mc, 66, 0, 0, 1, st_ok, 0);
      run(48'hffffffffffff, 65, 0, 0, 1, st_ok, 0);
      run(sta, 70, 0, 1, 1, st_fcs_err, 0);
      run(sta, 66, 5, 0, 1, st_ok, 0);
      run(sta, 66, 3, 1, 1, st_align_err, 0);
      run(sta, 63, 0, 0, 0, st_ok, 0);
      run(sta, 63, 7, 0, 0, st_ok, 0);
      repeat (6) begin
         xb = $urandom_range(1) ? 0 : $urandom_range(7, 1);
         bad = $urandom_range(1);
         run(sta, $urandom_range(80, 64), xb, bad, 1, bad ? (xb ? st_align_err : st_fcs_err) : st_ok, 0);
      end
      run(sta, 80, 0, 0, 1, st_overrun, 2);
      run(sta, 1520, 0, 0, 1, st_too_long, 1);
      conclude();
   end
endmodule : testbench
